//--- hdl/gam_map.vh
`ifndef GAM_MAP_VH
`define GAM_MAP_VH
// =====================================================
// timing
`define GAM_CLK_HZ 200000000
`define GAM_TICK_S 1
`define GAM_HUNT_WINDOW_S 8'h0A
`define GAM_HUNT_LIMIT 8'h06
// =====================================================
// setting selector codes
`define GAM_SEL_THR1 3'h0
`define GAM_SEL_THR2 3'h1
`define GAM_SEL_HYS1 3'h2
`define GAM_SEL_HYS2 3'h3
`define GAM_SEL_DWL1 3'h4
`define GAM_SEL_DWL2 3'h5
// =====================================================
// reset values and limits
`define GAM_THR1_RST 16'h0014
`define GAM_THR2_RST 16'h0028
`define GAM_HYS_RST 16'h0000
`define GAM_HYS_MAX 16'h0064
`define GAM_DWL_RST 16'h0001
`define GAM_DWL_MAX 16'h003C
`define GAM_FULL_SCALE 16'h0064
`define GAM_PERMILLE 32'h000003E8
// =====================================================
// fault limits and codes
`define GAM_ADC_MIN 16'h0010
`define GAM_ADC_MAX 16'hFFEF
`define GAM_SUPPLY_MIN_DV 16'h00AA
`define GAM_F_NONE 8'h00
`define GAM_F_ABSENT 8'h01
`define GAM_F_HIGH 8'h02
`define GAM_F_LOW 8'h03
`define GAM_F_CSUM 8'h04
`define GAM_F_SUPPLY 8'h05
`define GAM_F_HUNT 8'h08
`endif

//--- hdl/gam_alarm.v
`timescale 1ns/10ps
// =====================================================
// one alarm channel: threshold, band, dwell, release
module gam_alarm #(
    parameter VW = 16
) (
    input wire clk_in,
    input wire nrst_in,
    input wire tick_in,
    input wire sample_valid_in,
    input wire [VW-1:0] value_in,
    input wire [VW-1:0] threshold_in,
    input wire [VW-1:0] band_in,
    input wire [VW-1:0] dwell_in,
    input wire rising_in,
    input wire manual_in,
    input wire op_reset_in,
    output reg active_out
);
    // upper and lower switching points, saturated low
    wire [VW:0] hi_pt = {1'b0, threshold_in} + {1'b0, band_in};
    wire [VW:0] lo_pt = (band_in > threshold_in) ? {(VW+1){1'b0}} :
        ({1'b0, threshold_in} - {1'b0, band_in});
    wire [VW:0] val = {1'b0, value_in};
    wire no_band = (band_in == {VW{1'b0}});
    // entry condition per direction
    wire on_cond = rising_in ? (val >= hi_pt) : (val <= lo_pt);
    // keep condition: release at the far side of the band
    wire hold_cond = rising_in ?
        (no_band ? (val >= hi_pt) : (val > lo_pt)) :
        (no_band ? (val <= lo_pt) : (val < hi_pt));
    reg qual; // last sample met entry condition
    reg held; // last sample met keep condition
    reg [VW-1:0] dwell_cnt; // whole seconds qualified
    // =====================================================
    // sample the conditions
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            qual <= 1'b0;
            held <= 1'b0;
        end
        else if (sample_valid_in)
        begin
            qual <= on_cond;
            held <= hold_cond;
        end
    end
    // =====================================================
    // dwell counter, restarts when condition breaks
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            dwell_cnt <= {VW{1'b0}};
        else if (!qual)
            dwell_cnt <= {VW{1'b0}};
        else if (tick_in && dwell_cnt < dwell_in)
            dwell_cnt <= dwell_cnt + {{(VW-1){1'b0}}, 1'b1};
    end
    // =====================================================
    // alarm state with auto or latched release
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            active_out <= 1'b0;
        else if (!active_out)
        begin
            if (qual && dwell_cnt >= dwell_in)
                active_out <= 1'b1;
        end
        else if (manual_in)
        begin
            if (op_reset_in && !held)
                active_out <= 1'b0;
        end
        else if (!held)
            active_out <= 1'b0;
    end
endmodule // gam_alarm

//--- hdl/gam_hunt.v
`timescale 1ns/10ps
`include "gam_map.vh"
// =====================================================
// reading hunting detector: reversals per window
module gam_hunt #(
    parameter VW = 16,
    parameter CW = 8,
    parameter [CW-1:0] WINDOW_S = `GAM_HUNT_WINDOW_S,
    parameter [CW-1:0] LIMIT = `GAM_HUNT_LIMIT
) (
    input wire clk_in,
    input wire nrst_in,
    input wire tick_in,
    input wire sample_valid_in,
    input wire [VW-1:0] value_in,
    input wire clear_in,
    output reg fault_out
);
    reg [VW-1:0] last_val; // previous sample
    reg last_up; // direction of last move
    reg moved; // a direction is known
    reg [CW-1:0] rev_cnt; // reversals this window
    reg [CW-1:0] win_cnt; // seconds into window
    wire up = value_in > last_val;
    wire dn = value_in < last_val;
    wire rev = sample_valid_in && moved &&
        ((up && !last_up) || (dn && last_up));
    wire win_end = tick_in && (win_cnt >= WINDOW_S - 8'h01);
    wire over = rev_cnt > LIMIT;
    // =====================================================
    // track direction of successive samples
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            last_val <= {VW{1'b0}};
            last_up <= 1'b0;
            moved <= 1'b0;
        end
        else if (sample_valid_in)
        begin
            last_val <= value_in;
            if (up || dn)
            begin
                last_up <= up;
                moved <= 1'b1;
            end
        end
    end
    // =====================================================
    // window and reversal counters
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            win_cnt <= {CW{1'b0}};
            rev_cnt <= {CW{1'b0}};
        end
        else if (win_end)
        begin
            win_cnt <= {CW{1'b0}};
            rev_cnt <= {CW{1'b0}};
        end
        else
        begin
            if (tick_in)
                win_cnt <= win_cnt + 8'h01;
            if (rev && !over)
                rev_cnt <= rev_cnt + 8'h01;
        end
    end
    // =====================================================
    // sticky fault, set wins over clear
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            fault_out <= 1'b0;
        else if (over)
            fault_out <= 1'b1;
        else if (clear_in)
            fault_out <= 1'b0;
    end
endmodule // gam_hunt

//--- hdl/gam_top.v
`timescale 1ns/10ps
`include "gam_map.vh"
// =====================================================
// gas alarm and fault monitor, top level
module gam_top #(
    parameter VW = 16,
    parameter [31:0] TICK_CYCLES = `GAM_TICK_S * `GAM_CLK_HZ
) (
    input wire clk_in,
    input wire nrst_in,
    // converter front end
    input wire sample_valid_in,
    input wire [VW-1:0] gas_value_in,
    input wire [VW-1:0] adc_code_in,
    input wire sensor_present_in,
    input wire [VW-1:0] supply_dv_in,
    // stored configuration check
    input wire csum_check_in,
    input wire csum_ok_in,
    // setting editor
    input wire [2:0] edit_sel_in,
    input wire key_up_in,
    input wire key_down_in,
    input wire confirm_key_in,
    // alarm options
    input wire first_alarm_direction_in,
    input wire second_alarm_direction_in,
    input wire first_alarm_relay_gate_in,
    input wire second_alarm_relay_gate_in,
    input wire manual_release_in,
    input wire op_reset_in,
    // outputs
    output wire first_relay_out,
    output wire second_relay_out,
    output wire first_alarm_active_out,
    output wire second_alarm_active_out,
    output reg [VW-1:0] edit_value_out,
    output reg [5:0] fault_bits_out,
    output reg [7:0] fault_code_out,
    output wire fault_out,
    output reg sec_tick_out
);
    // =====================================================
    // functions
    // band in counts from tenths of a percent of full scale
    function [VW-1:0] gam_band;
        input [VW-1:0] hys;
        reg [31:0] prod;
        begin
            prod = ({16'h0000, hys} * {16'h0000, `GAM_FULL_SCALE}) /
                `GAM_PERMILLE;
            gam_band = prod[VW-1:0];
        end
    endfunction
    // upper limit of each editable setting
    function [VW-1:0] gam_sel_max;
        input [2:0] sel;
        begin
            case (sel)
                `GAM_SEL_THR1: gam_sel_max = `GAM_FULL_SCALE;
                `GAM_SEL_THR2: gam_sel_max = `GAM_FULL_SCALE;
                `GAM_SEL_HYS1: gam_sel_max = `GAM_HYS_MAX;
                `GAM_SEL_HYS2: gam_sel_max = `GAM_HYS_MAX;
                `GAM_SEL_DWL1: gam_sel_max = `GAM_DWL_MAX;
                `GAM_SEL_DWL2: gam_sel_max = `GAM_DWL_MAX;
                default: gam_sel_max = {VW{1'b0}};
            endcase
        end
    endfunction
    // =====================================================
    // committed settings
    reg [VW-1:0] thr1; // first threshold
    reg [VW-1:0] second_alarm_threshold; // second threshold
    reg [VW-1:0] hys1; // first band, 0.1 %FS
    reg [VW-1:0] second_alarm_hysteresis; // second band
    reg [VW-1:0] dwl1; // first dwell seconds
    reg [VW-1:0] second_alarm_dwell_seconds; // second dwell
    reg [2:0] last_sel; // selector seen last cycle
    reg [31:0] tick_cnt; // seconds divider
    reg csum_fault; // checksum fault, held until the next check
    reg [VW-1:0] cur_val; // committed value under selector
    reg [VW-1:0] next_edit; // next pending value
    wire [VW-1:0] sel_max = gam_sel_max(edit_sel_in);
    wire alarm1; // first alarm state
    wire alarm2; // second alarm state
    wire hunt_fault; // hunting detected
    // =====================================================
    // seconds tick divider
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            tick_cnt <= 32'h00000000;
            sec_tick_out <= 1'b0;
        end
        // wrap and emit one tick
        else if (tick_cnt >= TICK_CYCLES - 32'h00000001)
        begin
            tick_cnt <= 32'h00000000;
            sec_tick_out <= 1'b1;
        end
        // count toward next second
        else
        begin
            tick_cnt <= tick_cnt + 32'h00000001;
            sec_tick_out <= 1'b0;
        end
    end
    // =====================================================
    // committed value under the selector
    always @*
    begin
        case (edit_sel_in)
            `GAM_SEL_THR1: cur_val = thr1;
            `GAM_SEL_THR2: cur_val = second_alarm_threshold;
            `GAM_SEL_HYS1: cur_val = hys1;
            `GAM_SEL_HYS2: cur_val = second_alarm_hysteresis;
            `GAM_SEL_DWL1: cur_val = dwl1;
            `GAM_SEL_DWL2: cur_val = second_alarm_dwell_seconds;
            default: cur_val = {VW{1'b0}};
        endcase
    end
    // =====================================================
    // pending value: reload on new selector, step, clamp
    always @*
    begin
        next_edit = edit_value_out;
        if (edit_sel_in != last_sel)
            next_edit = cur_val; // reload shown value
        // step up, held at the top
        else if (key_up_in && !key_down_in)
        begin
            if (edit_value_out < sel_max)
                next_edit = edit_value_out +
                    {{(VW-1){1'b0}}, 1'b1};
        end
        // step down, held at zero
        else if (key_down_in && !key_up_in)
        begin
            if (edit_value_out != {VW{1'b0}})
                next_edit = edit_value_out -
                    {{(VW-1){1'b0}}, 1'b1};
        end
    end
    // =====================================================
    // editor registers
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            last_sel <= `GAM_SEL_THR1;
            edit_value_out <= `GAM_THR1_RST;
        end
        // remember selector, show pending
        else
        begin
            last_sel <= edit_sel_in;
            edit_value_out <= next_edit;
        end
    end
    // =====================================================
    // commit pending value on confirm
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            thr1 <= `GAM_THR1_RST;
            second_alarm_threshold <= `GAM_THR2_RST;
            hys1 <= `GAM_HYS_RST;
            second_alarm_hysteresis <= `GAM_HYS_RST;
            dwl1 <= `GAM_DWL_RST;
            second_alarm_dwell_seconds <= `GAM_DWL_RST;
        end
        // confirm void while selector moves
        else if (confirm_key_in && edit_sel_in == last_sel)
        begin
            case (edit_sel_in)
                `GAM_SEL_THR1: thr1 <= edit_value_out;
                `GAM_SEL_THR2:
                    second_alarm_threshold <= edit_value_out;
                `GAM_SEL_HYS1: hys1 <= edit_value_out;
                `GAM_SEL_HYS2:
                    second_alarm_hysteresis <= edit_value_out;
                `GAM_SEL_DWL1: dwl1 <= edit_value_out;
                `GAM_SEL_DWL2:
                    second_alarm_dwell_seconds <= edit_value_out;
                default: thr1 <= thr1;
            endcase
        end
    end
    // =====================================================
    // alarm channels; direction high means rising
    gam_alarm #(
        .VW(VW)
    ) u_alarm1 (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(sec_tick_out),
        .sample_valid_in(sample_valid_in),
        .value_in(gas_value_in),
        .threshold_in(thr1),
        .band_in(gam_band(hys1)),
        .dwell_in(dwl1),
        .rising_in(first_alarm_direction_in),
        .manual_in(manual_release_in),
        .op_reset_in(op_reset_in),
        .active_out(alarm1)
    );
    // second channel, second settings
    gam_alarm #(
        .VW(VW)
    ) u_alarm2 (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(sec_tick_out),
        .sample_valid_in(sample_valid_in),
        .value_in(gas_value_in),
        .threshold_in(second_alarm_threshold),
        .band_in(gam_band(second_alarm_hysteresis)),
        .dwell_in(second_alarm_dwell_seconds),
        .rising_in(second_alarm_direction_in),
        .manual_in(manual_release_in),
        .op_reset_in(op_reset_in),
        .active_out(alarm2)
    );
    // =====================================================
    // hunting detector
    gam_hunt #(
        .VW(VW)
    ) u_hunt (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(sec_tick_out),
        .sample_valid_in(sample_valid_in),
        .value_in(gas_value_in),
        .clear_in(op_reset_in),
        .fault_out(hunt_fault)
    );
    // =====================================================
    // relay gating and alarm status
    assign first_relay_out = first_alarm_relay_gate_in & alarm1;
    assign second_relay_out = second_alarm_relay_gate_in & alarm2;
    assign first_alarm_active_out = alarm1;
    assign second_alarm_active_out = alarm2;
    // any fault raises the summary
    assign fault_out = |fault_bits_out;
    // =====================================================
    // checksum fault follows each check result
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            csum_fault <= 1'b0;
        // each result replaces the last
        else if (csum_check_in)
            csum_fault <= !csum_ok_in;
    end
    // =====================================================
    // fault flags: absent, high, low, csum, supply, hunt
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            fault_bits_out <= 6'h00;
        else
        begin
            // level causes follow each cycle
            fault_bits_out[0] <= !sensor_present_in;
            // range causes move on samples
            if (sample_valid_in)
            begin
                fault_bits_out[1] <= sensor_present_in &&
                    adc_code_in > `GAM_ADC_MAX;
                fault_bits_out[2] <= sensor_present_in &&
                    adc_code_in < `GAM_ADC_MIN;
            end
            // checksum lags its check by two
            fault_bits_out[3] <= csum_fault;
            fault_bits_out[4] <= supply_dv_in < `GAM_SUPPLY_MIN_DV;
            fault_bits_out[5] <= hunt_fault;
        end
    end
    // =====================================================
    // lowest numbered active fault is reported
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            fault_code_out <= `GAM_F_NONE;
        else if (fault_bits_out[0])
            fault_code_out <= `GAM_F_ABSENT;
        else if (fault_bits_out[1])
            fault_code_out <= `GAM_F_HIGH;
        else if (fault_bits_out[2])
            fault_code_out <= `GAM_F_LOW;
        else if (fault_bits_out[3])
            fault_code_out <= `GAM_F_CSUM;
        else if (fault_bits_out[4])
            fault_code_out <= `GAM_F_SUPPLY;
        else if (fault_bits_out[5])
            fault_code_out <= `GAM_F_HUNT;
        // nothing active
        else
            fault_code_out <= `GAM_F_NONE;
    end
endmodule // gam_top

//--- tb/gam_fe_model.sv
`timescale 1ns/10ps
// =====================================================
// converter front end: one-cycle sample on request
module gam_fe_model (
    input wire clk_in,
    input wire go_in,
    input wire [15:0] value_in,
    input wire [15:0] code_in,
    output reg sample_valid_out = 1'b0,
    output reg [15:0] gas_out = 16'h0000,
    output reg [15:0] adc_out = 16'h0000
);
    // between samples the lines flip each cycle, never a stale copy
    always @(posedge clk_in)
    begin
        sample_valid_out <= go_in;
        gas_out <= go_in ? value_in : ~gas_out;
        adc_out <= go_in ? code_in : ~adc_out;
    end
endmodule // gam_fe_model

//--- tb/gam_top_sva.sv
`timescale 1ns/10ps
`include "gam_map.vh"
// =====================================================
// port checker for gam_top
module gam_top_chk #(
    parameter VW = 16,
    parameter [31:0] TICK_CYCLES = 32'h00000014
) (
    input wire clk_in,
    input wire nrst_in,
    input wire sample_valid_in,
    input wire [VW-1:0] adc_code_in,
    input wire sensor_present_in,
    input wire [VW-1:0] supply_dv_in,
    input wire csum_check_in,
    input wire csum_ok_in,
    input wire first_alarm_relay_gate_in,
    input wire second_alarm_relay_gate_in,
    input wire first_relay_out,
    input wire second_relay_out,
    input wire first_alarm_active_out,
    input wire second_alarm_active_out,
    input wire [5:0] fault_bits_out,
    input wire [7:0] fault_code_out,
    input wire fault_out,
    input wire sec_tick_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // =====================================================
    // relays and fault summary
    a_relay1_gate: assert property (first_relay_out ==
        (first_alarm_relay_gate_in && first_alarm_active_out))
        else $error("first relay not gate and alarm");
    a_relay2_gate: assert property (second_relay_out ==
        (second_alarm_relay_gate_in && second_alarm_active_out))
        else $error("second relay not gate and alarm");
    a_fault_any: assert property (fault_out == (|fault_bits_out))
        else $error("fault summary wrong");
    // =====================================================
    // fault causes, codes and tick spacing
    a_absent_set: assert property (!sensor_present_in |=>
        fault_bits_out[0]) else $error("absent fault missing");
    a_code_absent: assert property (fault_bits_out[0] |=>
        fault_code_out == `GAM_F_ABSENT) else $error("code not 01");
    a_code_none: assert property (fault_bits_out == 6'h00 |=>
        fault_code_out == `GAM_F_NONE) else $error("code not 00");
    a_high_range: assert property (sample_valid_in &&
        sensor_present_in && adc_code_in > `GAM_ADC_MAX |->
        ##[1:2] fault_bits_out[1]) else $error("high fault missing");
    a_low_range: assert property (sample_valid_in &&
        sensor_present_in && adc_code_in < `GAM_ADC_MIN |->
        ##[1:2] fault_bits_out[2]) else $error("low fault missing");
    a_csum_bad: assert property (csum_check_in && !csum_ok_in |->
        ##2 fault_bits_out[3]) else $error("checksum fault missing");
    a_supply_low: assert property (
        (supply_dv_in < `GAM_SUPPLY_MIN_DV) |=> fault_bits_out[4])
        else $error("supply fault missing");
    a_supply_ok: assert property (
        (supply_dv_in >= `GAM_SUPPLY_MIN_DV) |=> !fault_bits_out[4])
        else $error("supply fault false");
    a_tick_gap: assert property ($rose(sec_tick_out) |=>
        !sec_tick_out [*8]) else $error("tick too close");
    c_relay2: cover property (second_relay_out);
    c_hunt: cover property (fault_code_out == `GAM_F_HUNT);
    c_both: cover property (first_alarm_active_out && second_alarm_active_out);
endmodule // gam_top_chk
bind gam_top gam_top_chk #(.VW(VW), .TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_in, .nrst_in, .sample_valid_in, .adc_code_in, .sensor_present_in,
    .supply_dv_in, .csum_check_in, .csum_ok_in, .first_alarm_relay_gate_in,
    .second_alarm_relay_gate_in, .first_relay_out, .second_relay_out,
    .first_alarm_active_out, .second_alarm_active_out, .fault_bits_out,
    .fault_code_out, .fault_out, .sec_tick_out);

//--- tb/gam_top_tb_top.sv
`timescale 1ns/10ps
`include "gam_map.vh"
// =====================================================
// self-checking bench for gam_top
module gam_top_tb_top;
    reg clk_in = 1'b0;
    reg nrst_in = 1'b0;
    reg go = 1'b0; // sample request to front end
    reg [15:0] val = 16'h0000;
    reg [15:0] code = 16'h1000;
    reg present = 1'b1;
    reg [15:0] supply = 16'h00F0;
    reg cchk = 1'b0;
    reg cok = 1'b1;
    reg [2:0] sel = 3'h0;
    reg up = 1'b0;
    reg dn = 1'b0;
    reg conf = 1'b0;
    reg dir1 = 1'b1;
    reg dir2 = 1'b1;
    reg gate1 = 1'b1;
    reg gate2 = 1'b1;
    reg man = 1'b0;
    reg opr = 1'b0;
    reg [15:0] lfsr = 16'h005B; // seed 91
    wire sv, rly1, rly2, act1, act2, fo, tick;
    wire [15:0] gas, adc, edv;
    wire [5:0] fb;
    wire [7:0] fc;
    integer n_fail = 0;
    integer cmp_count = 0;
    integer cyc = 0;
    integer i;
    always #2.5 clk_in = ~clk_in;
    // cycle ceiling against hangs
    always @(posedge clk_in)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            n_fail = n_fail + 1;
            stop_test;
        end
    end
    gam_fe_model fe (.clk_in(clk_in), .go_in(go), .value_in(val),
        .code_in(code), .sample_valid_out(sv), .gas_out(gas), .adc_out(adc));
    gam_top #(.TICK_CYCLES(32'h00000014)) dut (.clk_in(clk_in),
        .nrst_in(nrst_in), .sample_valid_in(sv), .gas_value_in(gas),
        .adc_code_in(adc), .sensor_present_in(present),
        .supply_dv_in(supply), .csum_check_in(cchk), .csum_ok_in(cok),
        .edit_sel_in(sel), .key_up_in(up), .key_down_in(dn),
        .confirm_key_in(conf), .first_alarm_direction_in(dir1),
        .second_alarm_direction_in(dir2), .first_alarm_relay_gate_in(gate1),
        .second_alarm_relay_gate_in(gate2), .manual_release_in(man),
        .op_reset_in(opr), .first_relay_out(rly1), .second_relay_out(rly2),
        .first_alarm_active_out(act1), .second_alarm_active_out(act2),
        .edit_value_out(edv), .fault_bits_out(fb), .fault_code_out(fc),
        .fault_out(fo), .sec_tick_out(tick));
    // =====================================================
    // helpers
    function [15:0] rnd(input [15:0] s);
        rnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected fault code for cause index
    function [7:0] fcode(input integer k);
        fcode = (k == 4) ? `GAM_F_SUPPLY : k + 1;
    endfunction
    task w(input integer n);
        repeat (n)
        begin
            @(posedge clk_in);
            #1;
        end
    endtask
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one sample; m 1 above range, 2 below range, else random legal
    task samp(input [15:0] v, input [1:0] m);
        lfsr = rnd(lfsr);
        val = v;
        code = (m == 2'h1) ? 16'hFFF0 : (m == 2'h2) ? 16'h000F :
            {4'h1, lfsr[11:0]};
        go = 1'b1;
        w(1);
        go = 1'b0;
        w(4);
    endtask
    // step a setting, compare shown value, then commit
    task edit(input [2:0] s, input integer nu, input integer nd,
        input [15:0] e);
        sel = s;
        w(2);
        if (nu > 0)
        begin
            up = 1'b1;
            w(nu);
            up = 1'b0;
        end
        if (nd > 0)
        begin
            dn = 1'b1;
            w(nd);
            dn = 1'b0;
        end
        w(1);
        chk("setting", edv, e);
        conf = 1'b1;
        w(1);
        conf = 1'b0;
        w(1);
    endtask
    task pulse_reset;
        opr = 1'b1;
        w(1);
        opr = 1'b0;
        w(3);
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // =====================================================
    // main sequence
    initial
    begin
        w(4);
        nrst_in = 1'b1;
        w(1);
        chk("thr1 default", edv, 16'h0014);
        chk("fault code", fc, 16'h0000);
        // one fault cause at a time, then cleared
        for (i = 0; i < 5; i = i + 1)
        begin
            present = (i != 0);
            supply = (i == 4) ? 16'h00A9 : 16'h00AA;
            cchk = (i == 3);
            cok = (i != 3);
            w(1);
            cchk = 1'b0;
            samp(16'h000A, (i == 1) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0);
            chk("fault code", fc, fcode(i));
            present = 1'b1;
            supply = 16'h00AA;
            cchk = 1'b1;
            cok = 1'b1;
            w(1);
            cchk = 1'b0;
            samp(16'h000A, 2'h0);
            chk("fault clear", fc, 16'h0000);
        end
        $display("test faults done");
        edit(3'h1, 0, 0, 16'h0028);
        edit(3'h5, 70, 0, 16'h003C);
        edit(3'h5, 0, 70, 16'h0000);
        edit(3'h4, 0, 1, 16'h0000);
        edit(3'h1, 1, 0, 16'h0029);
        gate1 = 1'b0;
        samp(16'h0028, 2'h0);
        chk("alarm2", act2, 16'h0000);
        samp(16'h0029, 2'h0);
        chk("alarm2", act2, 16'h0001);
        chk("relay2", rly2, 16'h0001);
        chk("alarm1", act1, 16'h0001);
        chk("relay1", rly1, 16'h0000);
        gate2 = 1'b0;
        w(1);
        chk("relay2", rly2, 16'h0000);
        gate2 = 1'b1;
        samp(16'h0028, 2'h0);
        chk("alarm2", act2, 16'h0000);
        dir1 = 1'b0;
        samp(16'h0015, 2'h0);
        chk("alarm1", act1, 16'h0000);
        samp(16'h0014, 2'h0);
        chk("alarm1", act1, 16'h0001);
        edit(3'h1, 0, 1, 16'h0028);
        dir2 = 1'b0;
        samp(16'h0029, 2'h0);
        chk("alarm2", act2, 16'h0000);
        samp(16'h0028, 2'h0);
        chk("alarm2", act2, 16'h0001);
        dir2 = 1'b1;
        dir1 = 1'b1;
        $display("test direction done");
        edit(3'h3, 50, 0, 16'h0032);
        samp(16'h0014, 2'h0);
        samp(16'h002C, 2'h0);
        chk("band on", act2, 16'h0000);
        samp(16'h002D, 2'h0);
        chk("band on", act2, 16'h0001);
        samp(16'h0024, 2'h0);
        chk("band hold", act2, 16'h0001);
        samp(16'h0023, 2'h0);
        chk("band off", act2, 16'h0000);
        edit(3'h3, 0, 50, 16'h0000);
        $display("test band done");
        man = 1'b1;
        samp(16'h002D, 2'h0);
        pulse_reset;
        chk("latched", act2, 16'h0001);
        samp(16'h001E, 2'h0);
        chk("latched", act2, 16'h0001);
        pulse_reset;
        chk("released", act2, 16'h0000);
        man = 1'b0;
        $display("test manual done");
        edit(3'h5, 2, 0, 16'h0002);
        val = 16'h002D;
        go = 1'b1;
        w(3);
        chk("dwell early", act2, 16'h0000);
        w(60);
        chk("dwell late", act2, 16'h0001);
        go = 1'b0;
        samp(16'h001E, 2'h0);
        $display("test dwell done");
        for (i = 0; i < 20; i = i + 1)
            samp((i % 2) ? {11'h002, lfsr[4:0]} : {11'h000, lfsr[4:0]}, 2'h0);
        chk("hunt bit", fb[5], 16'h0001);
        chk("hunt code", fc, 16'h0008);
        w(210);
        pulse_reset;
        chk("hunt clear", fb[5], 16'h0000);
        $display("test hunting done");
        stop_test;
    end
endmodule // gam_top_tb_top
